/* File: common/via_pkg.sv */
// constants, types and register map of the vectored interrupt arbiter
package via_pkg;

   // ****************************************
   // widths and timing
   // ****************************************
   localparam int PC_W = 15;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int SLOT_N = 16;
   localparam int SLOT_W = 4;
   localparam int MCLK_PERIOD_NS = 40;
   localparam int ICYCLE_NS = 1000;
   localparam int CLKS_PER_ICYCLE = (ICYCLE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam int ACK_ICYCLES = 7;
   localparam int ACK_CLKS = ACK_ICYCLES * CLKS_PER_ICYCLE;
   localparam int ACK_CNT_W = 8;

   // ****************************************
   // vector slots and addresses
   // ****************************************
   localparam logic [PC_W-1:0] ENTRY_ADDR = 15'h00FF;
   localparam logic [7:0] VEC_BASE = 8'hE0;
   localparam int SLOT_TRAP = 15;
   localparam int SLOT_DEFAULT = 0;
   // maskable slots, rank order 14 down to 1 (1 = port L wake up)
   localparam logic [SLOT_N-1:0] MASKABLE_SLOTS = 16'h7FFF & ~16'h0001;
   localparam logic [SLOT_N-1:0] SLOTS_RESET = 16'h0000;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [ADDR_W-1:0] REG_EN_LO = 8'h00;
   localparam logic [ADDR_W-1:0] REG_EN_HI = 8'h01;
   localparam logic [ADDR_W-1:0] REG_PEND_LO = 8'h02;
   localparam logic [ADDR_W-1:0] REG_PEND_HI = 8'h03;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
   localparam int ST_GIE_BIT = 0;
   localparam int ST_NMI_ACT_BIT = 1;
   localparam int ST_BUSY_BIT = 2;
   localparam int ST_TRAP_PEND_BIT = 3;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {
      VIA_IDLE = 2'b01,
      VIA_ACK = 2'b10
   } via_state_t;

   // instruction sequencer view of the current instruction
   typedef struct packed {
      logic instr_start;
      logic skip_next;
      logic vector_select_instruction;
      logic return_from_irq_instruction;
      logic clear_nmi_pending_instruction;
      logic [PC_W-1:0] next_pc;
      logic [PC_W-1:0] cur_pc;
      logic [PC_W-1:0] pop_pc;
   } via_cpu_op_t;

   // commands back to the sequencer
   typedef struct packed {
      logic push;
      logic [PC_W-1:0] push_addr;
      logic load;
      logic [PC_W-1:0] load_addr;
   } via_pc_cmd_t;

endpackage : via_pkg

/* File: rtl/via_prio.sv */
// fixed priority picker over the vector slots
`timescale 1ns/10ps
`default_nettype none
module via_prio #(
   parameter int N = 16,
   parameter int W = 4
) (
   // candidates, bit index is the rank slot
   input wire logic [N-1:0] active,
   // winner
   output logic [W-1:0] win_slot,
   output logic any
);

   // ****************************************
   // highest index wins, zero when none
   // ****************************************
   always_comb begin
      win_slot = '0;
      for (int i = 1; i < N; i++) begin
         if (active[i]) begin
            win_slot = W'(i); // later, higher slot overrides
         end
      end
      any = |active[N-1:1];
   end

endmodule : via_prio
`default_nettype wire

/* File: rtl/via_arbiter.sv */
// vectored interrupt arbiter: pending, enables, acknowledge sequence, vector select
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module via_arbiter (
   // clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // register port
   input wire logic [via_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [via_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [via_pkg::DATA_W-1:0] reg_rdata,
   // interrupt sources, one pulse per event, bit index is slot
   input wire logic [via_pkg::SLOT_N-1:0] src_event,
   // instruction sequencer
   input wire via_pkg::via_cpu_op_t cpu_op,
   output via_pkg::via_pc_cmd_t pc_cmd,
   output logic irq_req,
   output logic ack_busy
);

   // ****************************************
   // state
   // ****************************************
   via_pkg::via_state_t state_q;
   logic [via_pkg::SLOT_N-1:0] en_q;
   logic [via_pkg::SLOT_N-1:0] pend_q;
   logic gie_q;
   logic nmi_act_q;
   logic [via_pkg::ACK_CNT_W-1:0] cnt_q;
   logic take_trap_q;
   // one-hot helper for single slot masks
   localparam logic [via_pkg::SLOT_N-1:0] SLOT_N_ONE = 16'h0001;

   // ****************************************
   // decode helpers
   // ****************************************
   // write strobe for one register address
   function automatic logic wr_hit(input logic wr, input logic [via_pkg::ADDR_W-1:0] a,
                                   input logic [via_pkg::ADDR_W-1:0] r);
      wr_hit = wr && (a == r);
   endfunction : wr_hit

   // merge a written byte into the 16 bit slot vector
   function automatic logic [via_pkg::SLOT_N-1:0] merge(input logic [via_pkg::SLOT_N-1:0] cur,
                                                        input logic lo, input logic hi,
                                                        input logic [via_pkg::DATA_W-1:0] d);
      logic [via_pkg::SLOT_N-1:0] v;
      v = cur;
      if (lo) begin
         v[7:0] = d;
      end
      if (hi) begin
         v[15:8] = d;
      end
      merge = v;
   endfunction : merge

   logic en_lo_wr, en_hi_wr, pd_lo_wr, pd_hi_wr, st_wr;
   assign en_lo_wr = wr_hit(reg_wr, reg_addr, via_pkg::REG_EN_LO);
   assign en_hi_wr = wr_hit(reg_wr, reg_addr, via_pkg::REG_EN_HI);
   assign pd_lo_wr = wr_hit(reg_wr, reg_addr, via_pkg::REG_PEND_LO);
   assign pd_hi_wr = wr_hit(reg_wr, reg_addr, via_pkg::REG_PEND_HI);
   assign st_wr = wr_hit(reg_wr, reg_addr, via_pkg::REG_STATUS);

   // ****************************************
   // request qualification
   // ****************************************
   logic [via_pkg::SLOT_N-1:0] active;
   logic [via_pkg::SLOT_N-1:0] vis_cand;
   logic mask_req, trap_req, take;
   logic [via_pkg::SLOT_W-1:0] win_slot;
   logic win_any;

   // active sources: enabled and pending, maskable slots only
   assign active = en_q & pend_q & via_pkg::MASKABLE_SLOTS;
   assign mask_req = gie_q && !nmi_act_q && (|active);
   assign trap_req = pend_q[via_pkg::SLOT_TRAP] && !nmi_act_q; // trap ignores masks
   assign irq_req = mask_req || trap_req;
   // taken only at a boundary of a normally executed instruction
   assign take = (state_q == via_pkg::VIA_IDLE) && cpu_op.instr_start
                 && !cpu_op.skip_next && irq_req;

   // vector select sees the trap plus active maskable sources
   always_comb begin
      vis_cand = active;
      vis_cand[via_pkg::SLOT_TRAP] = pend_q[via_pkg::SLOT_TRAP];
   end

   via_prio #(
      .N(via_pkg::SLOT_N),
      .W(via_pkg::SLOT_W)
   ) u_prio (
      .active(vis_cand),
      .win_slot(win_slot),
      .any(win_any)
   );

   // ****************************************
   // acknowledge sequencer
   // ****************************************
   logic ack_last;
   assign ack_last = (state_q == via_pkg::VIA_ACK)
                     && (cnt_q == via_pkg::ACK_CNT_W'(via_pkg::ACK_CLKS - 2));
   assign ack_busy = (state_q == via_pkg::VIA_ACK);

   // state and cycle count of the acknowledge sequence
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= via_pkg::VIA_IDLE;
         cnt_q <= '0;
      end else begin
         case (state_q)
            via_pkg::VIA_IDLE: begin
               cnt_q <= '0;
               if (take) begin
                  state_q <= via_pkg::VIA_ACK;
               end
            end
            via_pkg::VIA_ACK: begin
               cnt_q <= cnt_q + 1'b1; // seven instruction cycles of clocks
               if (ack_last) begin
                  state_q <= via_pkg::VIA_IDLE;
               end
            end
            default: begin
               state_q <= via_pkg::VIA_IDLE;
               cnt_q <= '0;
            end
         endcase
      end
   end

   // remember whether the taken request was the trap
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         take_trap_q <= 1'b0;
      end else if (take) begin
         take_trap_q <= trap_req;
      end
   end

   // ****************************************
   // program counter commands
   // ****************************************
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pc_cmd <= '0;
      end else begin
         pc_cmd.push <= take;
         if (take) begin
            pc_cmd.push_addr <= cpu_op.next_pc; // return address pushed first
         end
         pc_cmd.load <= ack_last || (ack_busy ? 1'b0 : (cpu_op.vector_select_instruction || cpu_op.return_from_irq_instruction));
         if (ack_last) begin
            pc_cmd.load_addr <= via_pkg::ENTRY_ADDR; // common entry
         end else if (!ack_busy && cpu_op.vector_select_instruction) begin
            // high byte kept, low byte from winning slot
            pc_cmd.load_addr <= {cpu_op.cur_pc[via_pkg::PC_W-1:8],
                                 via_pkg::VEC_BASE + {3'b000, win_slot, 1'b0}};
         end else if (!ack_busy && cpu_op.return_from_irq_instruction) begin
            pc_cmd.load_addr <= cpu_op.pop_pc; // popped return address
         end
      end
   end

   // ****************************************
   // global enable and trap service flag
   // ****************************************
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         gie_q <= 1'b0;
      end else if (take) begin
         gie_q <= 1'b0; // cleared at start of acknowledge
      end else if (!ack_busy && cpu_op.return_from_irq_instruction) begin
         gie_q <= 1'b1;
      end else if (st_wr) begin
         gie_q <= reg_wdata[via_pkg::ST_GIE_BIT]; // software may nest
      end
   end

   // trap service in progress blocks maskable sources
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         nmi_act_q <= 1'b0;
      end else if (take && trap_req) begin
         nmi_act_q <= 1'b1;
      end else if (!ack_busy && cpu_op.return_from_irq_instruction) begin
         nmi_act_q <= 1'b0;
      end
   end

   // ****************************************
   // enables and pending flags
   // ****************************************
   // enables, written by software, maskable slots only
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         en_q <= via_pkg::SLOTS_RESET;
      end else begin
         en_q <= merge(en_q, en_lo_wr, en_hi_wr, reg_wdata) & via_pkg::MASKABLE_SLOTS;
      end
   end

   // pending: software writes maskable bits, events set, set wins over clear
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pend_q <= via_pkg::SLOTS_RESET;
      end else begin
         pend_q <= ((merge(pend_q, pd_lo_wr, pd_hi_wr, reg_wdata) & via_pkg::MASKABLE_SLOTS)
                   | (pend_q & ~via_pkg::MASKABLE_SLOTS & ~(SLOT_N_ONE << via_pkg::SLOT_DEFAULT))
                   & ~((cpu_op.clear_nmi_pending_instruction && !ack_busy) ? (SLOT_N_ONE << via_pkg::SLOT_TRAP) : '0))
                   | (src_event & ~(SLOT_N_ONE << via_pkg::SLOT_DEFAULT));
      end
   end

   // ****************************************
   // register read port
   // ****************************************
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            via_pkg::REG_EN_LO: reg_rdata <= en_q[7:0];
            via_pkg::REG_EN_HI: reg_rdata <= en_q[15:8];
            via_pkg::REG_PEND_LO: reg_rdata <= pend_q[7:0];
            via_pkg::REG_PEND_HI: reg_rdata <= pend_q[15:8];
            via_pkg::REG_STATUS: begin
               reg_rdata <= '0;
               reg_rdata[via_pkg::ST_GIE_BIT] <= gie_q;
               reg_rdata[via_pkg::ST_NMI_ACT_BIT] <= nmi_act_q;
               reg_rdata[via_pkg::ST_BUSY_BIT] <= ack_busy;
               reg_rdata[via_pkg::ST_TRAP_PEND_BIT] <= pend_q[via_pkg::SLOT_TRAP];
            end
            default: reg_rdata <= '0;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   // cycles since the last take, counted only while acknowledge is busy, read by checks only
   logic [via_pkg::ACK_CNT_W-1:0] since_take_q;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         since_take_q <= '0;
      end else if (take) begin
         since_take_q <= 8'h01;
      end else if (ack_busy) begin
         since_take_q <= since_take_q + 1'b1;
      end
   end

   a_ack_gie_clear: assert property (@(posedge mclk) disable iff (!reset_n)
      take |=> !gie_q && ack_busy)
      else $error("global enable not cleared at acknowledge");

   a_ack_push_ret: assert property (@(posedge mclk) disable iff (!reset_n)
      take |=> pc_cmd.push && pc_cmd.push_addr == $past(cpu_op.next_pc) && !pc_cmd.load)
      else $error("return address not pushed at acknowledge");

   a_ack_entry_jump: assert property (@(posedge mclk) disable iff (!reset_n)
      ack_last |=> pc_cmd.load && pc_cmd.load_addr == via_pkg::ENTRY_ADDR && !ack_busy)
      else $error("acknowledge did not jump to entry");

   a_ack_length: assert property (@(posedge mclk) disable iff (!reset_n)
      ($fell(ack_busy)) |-> since_take_q == via_pkg::ACK_CNT_W'(via_pkg::ACK_CLKS) && pc_cmd.load)
      else $error("acknowledge length wrong");

   a_mask_gating: assert property (@(posedge mclk) disable iff (!reset_n)
      (take && !trap_req) |-> gie_q && !nmi_act_q && (|(en_q & pend_q)))
      else $error("maskable taken without qualification");

   a_take_boundary: assert property (@(posedge mclk) disable iff (!reset_n)
      (cpu_op.skip_next || !cpu_op.instr_start) |=> !pc_cmd.push)
      else $error("acknowledge off instruction boundary");

   a_vis_default: assert property (@(posedge mclk) disable iff (!reset_n)
      (cpu_op.vector_select_instruction && !ack_busy && !(|vis_cand)) |=> pc_cmd.load && pc_cmd.load_addr[7:0] == via_pkg::VEC_BASE)
      else $error("default vector not selected");

   a_vis_trap_top: assert property (@(posedge mclk) disable iff (!reset_n)
      (cpu_op.vector_select_instruction && !ack_busy && pend_q[15])
      |=> pc_cmd.load_addr == {$past(cpu_op.cur_pc[14:8]), 8'hFE})
      else $error("trap not top vector");

   a_return_from_irq_instruction_restore: assert property (@(posedge mclk) disable iff (!reset_n)
      (cpu_op.return_from_irq_instruction && !ack_busy && !take) |=> gie_q && pc_cmd.load
      && pc_cmd.load_addr == $past(cpu_op.pop_pc))
      else $error("return did not restore");

   a_event_sets: assert property (@(posedge mclk) disable iff (!reset_n)
      ##1 ((pend_q & $past(src_event) & 16'hFFFE) == ($past(src_event) & 16'hFFFE)))
      else $error("event lost from pending");

   a_pend_sticky: assert property (@(posedge mclk) disable iff (!reset_n)
      (pend_q[3] && !pd_lo_wr) |=> pend_q[3])
      else $error("pending flag dropped without clear");

   // ****************************************
   // checks on priority, masking and reset
   // ****************************************
   a_vis_rank_top: assert property (@(posedge mclk) disable iff (!reset_n)
      (cpu_op.vector_select_instruction && !ack_busy && win_any) |-> (vis_cand >> win_slot) == via_pkg::SLOT_N'(1))
      else $error("vector select missed the top active slot");

   a_clear_nmi_pending_instruction_clear: assert property (@(posedge mclk) disable iff (!reset_n)
      (cpu_op.clear_nmi_pending_instruction && !ack_busy && !src_event[via_pkg::SLOT_TRAP]) |=> !pend_q[via_pkg::SLOT_TRAP])
      else $error("trap pending not cleared");

   a_trap_pend_sticky: assert property (@(posedge mclk) disable iff (!reset_n)
      (pend_q[via_pkg::SLOT_TRAP] && !(cpu_op.clear_nmi_pending_instruction && !ack_busy)) |=> pend_q[via_pkg::SLOT_TRAP])
      else $error("trap pending dropped without clear");

   a_gie_nest_set: assert property (@(posedge mclk) disable iff (!reset_n)
      (st_wr && reg_wdata[via_pkg::ST_GIE_BIT] && !take) |=> gie_q)
      else $error("global enable write ignored");

   a_trap_service_flag: assert property (@(posedge mclk) disable iff (!reset_n)
      (ack_busy && take_trap_q) |-> nmi_act_q)
      else $error("trap service flag missing during acknowledge");

   a_return_from_irq_instruction_release: assert property (@(posedge mclk) disable iff (!reset_n)
      (cpu_op.return_from_irq_instruction && !ack_busy && !take) |=> !nmi_act_q)
      else $error("return left trap service flag set");

   a_reset_clear: assert property (@(posedge mclk)
      !reset_n |=> pend_q == via_pkg::SLOTS_RESET && en_q == via_pkg::SLOTS_RESET && !gie_q)
      else $error("reset left state set");

   a_en_maskable_only: assert property (@(posedge mclk) disable iff (!reset_n)
      !en_q[via_pkg::SLOT_TRAP] && !en_q[via_pkg::SLOT_DEFAULT])
      else $error("enable bit held on a non-maskable slot");

   a_skip_defers: assert property (@(posedge mclk) disable iff (!reset_n)
      (cpu_op.skip_next && !ack_busy) |=> !ack_busy)
      else $error("acknowledge started on a skipped instruction");

endmodule : via_arbiter
`default_nettype wire

/* File: tb/via_cpu_model.sv */
// behavioural instruction sequencer facing the interrupt arbiter
`timescale 1ns/10ps
`default_nettype none
module via_cpu_model (
   // clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // bench control
   input wire logic run,
   input wire logic skip,
   input wire logic vis_go,
   input wire logic return_from_irq_instruction_go,
   input wire logic clear_nmi_pending_instruction_go,
   input wire logic [14:0] cur_pc,
   // arbiter side
   input wire via_pkg::via_pc_cmd_t pc_cmd,
   input wire logic ack_busy,
   output via_pkg::via_cpu_op_t cpu_op
);
   // ****************************************
   // instruction pacing and return stack
   // ****************************************
   logic [1:0] cnt_q;
   logic [14:0] stack_q;

   // four clocks per instruction, frozen during acknowledge
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) cnt_q <= 2'h0;
      else if (!ack_busy) cnt_q <= cnt_q + 2'h1;
   end

   // one-deep stack catches the pushed return address
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) stack_q <= 15'h0000;
      else if (pc_cmd.push) stack_q <= pc_cmd.push_addr;
   end

   // instruction view handed to the arbiter
   always_comb begin
      cpu_op.instr_start = run && !ack_busy && (cnt_q == 2'h0);
      cpu_op.skip_next = skip;
      cpu_op.vector_select_instruction = vis_go;
      cpu_op.return_from_irq_instruction = return_from_irq_instruction_go;
      cpu_op.clear_nmi_pending_instruction = clear_nmi_pending_instruction_go;
      cpu_op.cur_pc = cur_pc;
      cpu_op.next_pc = cur_pc + 15'h0001;
      cpu_op.pop_pc = stack_q;
   end
endmodule : via_cpu_model
`default_nettype wire

/* File: tb/tb.sv */
// self-checking testbench for the vectored interrupt arbiter
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
   $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module tb;
   // ****************************************
   // signals
   // ****************************************
   logic mclk, reset_n, reg_wr, reg_rd, run, skip, vis_go, return_from_irq_instruction_go, clear_nmi_pending_instruction_go;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [15:0] src_event;
   logic [14:0] cur_pc;
   via_pkg::via_cpu_op_t cpu_op;
   via_pkg::via_pc_cmd_t pc_cmd;
   logic irq_req, ack_busy;
   int fail_count, compares;

   via_arbiter dut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_event(src_event),
      .cpu_op(cpu_op), .pc_cmd(pc_cmd), .irq_req(irq_req), .ack_busy(ack_busy));
   via_cpu_model cpu (.mclk(mclk), .reset_n(reset_n), .run(run), .skip(skip), .vis_go(vis_go),
      .return_from_irq_instruction_go(return_from_irq_instruction_go), .clear_nmi_pending_instruction_go(clear_nmi_pending_instruction_go), .cur_pc(cur_pc), .pc_cmd(pc_cmd),
      .ack_busy(ack_busy), .cpu_op(cpu_op));

   // clock generator
   initial begin
      mclk = 1'b0;
      forever #(via_pkg::MCLK_PERIOD_NS / 2) mclk = ~mclk;
   end

   // ****************************************
   // bus and instruction tasks
   // ****************************************
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask : rd

   task automatic ev(input logic [15:0] v);
      @(posedge mclk);
      src_event <= v;
      @(posedge mclk);
      src_event <= 16'h0000;
      #1;
   endtask : ev

   // k: 0 vector select, 1 return, 2 clear trap pending
   task automatic op(input int k, input logic [14:0] e);
      @(posedge mclk);
      vis_go <= (k == 0);
      return_from_irq_instruction_go <= (k == 1);
      clear_nmi_pending_instruction_go <= (k == 2);
      @(posedge mclk);
      vis_go <= 1'b0;
      return_from_irq_instruction_go <= 1'b0;
      clear_nmi_pending_instruction_go <= 1'b0;
      #1;
      if (k < 2) `CHK(pc_cmd.load, 1'b1)
      if (k < 2) `CHK(pc_cmd.load_addr, e)
   endtask : op

   // waits for the push, then times the entry jump
   task automatic take(input logic [14:0] ret);
      int n;
      n = 0;
      while (pc_cmd.push !== 1'b1 && n < 60) begin
         @(posedge mclk);
         #1;
         n++;
      end
      `CHK(pc_cmd.push, 1'b1)
      `CHK(pc_cmd.push_addr, ret)
      `CHK(ack_busy, 1'b1)
      n = 0;
      while (pc_cmd.load !== 1'b1 && n < 300) begin
         @(posedge mclk);
         #1;
         n++;
      end
      `CHK(n, via_pkg::ACK_CLKS - 1)
      `CHK(ack_busy, 1'b0)
      `CHK(pc_cmd.load_addr, 15'h00FF)
      @(posedge mclk);
      run <= 1'b0;
   endtask : take

   task finish_test;
      if (fail_count == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : finish_test

   // watchdog against a hung sequence
   initial begin
      repeat (5000) @(posedge mclk);
      fail_count++;
      finish_test();
   end

   // ****************************************
   // test sequence
   // ****************************************
   initial begin
      {reset_n, reg_wr, reg_rd, run, skip, vis_go, return_from_irq_instruction_go, clear_nmi_pending_instruction_go} = 8'h00;
      {reg_addr, reg_wdata, src_event} = 32'h0000_0000;
      cur_pc = 15'h0123;
      fail_count = 0;
      compares = 0;
      repeat (16) @(posedge mclk);
      reset_n <= 1'b1;
      for (int a = 0; a < 5; a++) rd(8'(a), 8'h00);
      rd(8'h07, 8'h00);
      ev(16'h0209);
      rd(8'h02, 8'h08);
      rd(8'h03, 8'h02);
      wr(8'h00, 8'hFF);
      wr(8'h01, 8'hFF);
      rd(8'h00, 8'hFE);
      rd(8'h01, 8'h7F);
      `CHK(irq_req, 1'b0)
      wr(8'h04, 8'h01);
      `CHK(irq_req, 1'b1)
      op(0, 15'h01F2);
      wr(8'h03, 8'h00);
      op(0, 15'h01E6);
      wr(8'h02, 8'h00);
      op(0, 15'h01E0);
      ev(16'h0020);
      @(posedge mclk);
      skip <= 1'b1;
      run <= 1'b1;
      repeat (40) @(posedge mclk);
      #1;
      `CHK(ack_busy, 1'b0)
      @(posedge mclk);
      skip <= 1'b0;
      take(15'h0124);
      rd(8'h04, 8'h00);
      rd(8'h02, 8'h20);
      wr(8'h04, 8'h01);
      `CHK(irq_req, 1'b1)
      wr(8'h04, 8'h00);
      op(1, 15'h0124);
      rd(8'h04, 8'h01);
      `CHK(irq_req, 1'b1)
      wr(8'h02, 8'h00);
      ev(16'h8000);
      rd(8'h04, 8'h09);
      @(posedge mclk);
      run <= 1'b1;
      take(15'h0124);
      rd(8'h04, 8'h0A);
      ev(16'h0020);
      wr(8'h04, 8'h01);
      `CHK(irq_req, 1'b0)
      op(0, 15'h01FE);
      op(2, 15'h0000);
      rd(8'h04, 8'h03);
      op(1, 15'h0124);
      `CHK(irq_req, 1'b1)
      @(posedge mclk);
      reset_n <= 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      rd(8'h00, 8'h00);
      rd(8'h02, 8'h00);
      rd(8'h04, 8'h00);
      `CHK(irq_req, 1'b0)
      finish_test();
   end
endmodule : tb
`default_nettype wire
